// file: core/rawsock_pkg.sv
// Constants, register map and state types of the raw socket channel.
// Assumes one 40 MHz clock and external synchronous buffer memories.
package rawsock_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int MEM_AW = 13;
    // ------------------------------------------------------------
    // Register groups (address bits 5:2), channel in bits 1:0
    // ------------------------------------------------------------
    localparam logic [3:0] GRP_SOPR = 4'h0;
    localparam logic [3:0] GRP_IPR = 4'h1;
    localparam logic [3:0] GRP_RXWR = 4'h2;
    localparam logic [3:0] GRP_RXRD = 4'h3;
    localparam logic [3:0] GRP_TXWR = 4'h4;
    localparam logic [3:0] GRP_TXRD = 4'h5;
    localparam logic [ADDR_W-1:0] CMD_ADDR = 6'h18;
    localparam logic [ADDR_W-1:0] INT_STAT_ADDR = 6'h19;
    localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 6'h1A;
    localparam logic [ADDR_W-1:0] MODE_STAT_ADDR = 6'h1B;
    localparam logic [ADDR_W-1:0] HWADDR_HI_ADDR = 6'h1C;
    localparam logic [ADDR_W-1:0] HWADDR_MID_ADDR = 6'h1D;
    localparam logic [ADDR_W-1:0] HWADDR_LO_ADDR = 6'h1E;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int CMD_INIT_BIT = 8;
    localparam int CMD_SEND_BIT = 9;
    localparam logic [3:0] IP_RAW_PROTOCOL_CODE = 4'h3;
    localparam logic [3:0] MAC_RAW_PROTOCOL_CODE = 4'h4;
    localparam int OPT_ERR_BIT = 5;
    localparam int OPT_BCAST_BIT = 6;
    localparam int OPT_PROMISC_BIT = 7;
    localparam int STT_MATCH_BIT = 7;
    localparam int STT_BCAST_BIT = 5;
    localparam int STT_ERR_BIT = 4;
    // ------------------------------------------------------------
    // Record layout and memory windows
    // ------------------------------------------------------------
    localparam logic [15:0] IP_HDR_LEN = 16'h0006;
    localparam logic [15:0] MAC_HDR_LEN = 16'h0003;
    localparam logic [15:0] CHAN_MEM_SIZE = 16'h0800;
    localparam logic [15:0] FULL_MEM_SIZE = 16'h2000;
    localparam logic [15:0] CHAN_MEM_MASK = 16'h07FF;
    localparam logic [15:0] FULL_MEM_MASK = 16'h1FFF;
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [47:0] HWADDR_RST = 48'h000000000000;
    typedef enum {RX_IDLE, RX_DATA, RX_HDR} rx_state_e;
    typedef enum {TX_IDLE, TX_ADDR, TX_READ, TX_SEND} tx_state_e;
endpackage

// file: core/sticky_irq.sv
// Sticky event flags with mask and one level interrupt.
// Assumes events and the clearing read come from the same clock.
`timescale 1ns/1ps
module sticky_irq #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic clr,
    input wire logic [W-1:0] mask,
    output logic [W-1:0] status,
    output logic irq
);
    logic [W-1:0] flag_ff;
    logic irq_ff;
    wire [W-1:0] nxt_flag = (clr ? {W{1'b0}} : flag_ff) | set;

    // A new event wins over the clearing read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            irq_ff <= |(nxt_flag & mask);
        end
    end

    assign status = flag_ff;
    assign irq = irq_ff;
endmodule

// file: core/rx_accept_filter.sv
// Receive acceptance: picks the channel that takes an incoming packet.
// Assumes attributes are valid beside the frame start pulse.
`timescale 1ns/1ps
module rx_accept_filter (
    input wire logic mac_mode,
    input wire logic [rawsock_pkg::NUM_CH-1:0] ip_act,
    input wire logic [rawsock_pkg::NUM_CH-1:0][7:0] ipr,
    input wire logic opt_bcast,
    input wire logic opt_promisc,
    input wire logic is_ip,
    input wire logic [7:0] ip_proto,
    input wire logic dst_match,
    input wire logic bcast,
    output logic accept,
    output logic [rawsock_pkg::CH_W-1:0] chan
);
    always_comb begin
        accept = 1'b0;
        chan = '0;
        if (mac_mode) begin
            accept = opt_promisc | dst_match | (bcast & opt_bcast);
        end else begin
            for (int i = rawsock_pkg::NUM_CH - 1; i >= 0; i--) begin
                if (ip_act[i] && is_ip && ipr[i] == ip_proto) begin
                    accept = 1'b1;
                    chan = i[rawsock_pkg::CH_W-1:0];
                end
            end
        end
    end
endmodule

// file: core/raw_mode_socket_channel.sv
// Raw-mode socket channels: record writer, frame sender, registers.
// Assumes MAC side and memories run on sys_clk; memories read in one cycle.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module raw_mode_socket_channel (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [rawsock_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rawsock_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rawsock_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    input wire logic rx_frame_start,
    input wire logic rx_is_ip,
    input wire logic [7:0] rx_ip_proto,
    input wire logic [31:0] rx_src_ip,
    input wire logic rx_dst_match,
    input wire logic rx_bcast,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic rx_frame_err,
    output logic rxm_we,
    output logic [rawsock_pkg::MEM_AW-1:0] rxm_addr,
    output logic [7:0] rxm_wdata,
    output logic [rawsock_pkg::MEM_AW-1:0] txm_addr,
    input wire logic [7:0] txm_rdata,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_mac_raw,
    output logic [7:0] tx_ip_proto,
    input wire logic tx_ready
);
    localparam int N = rawsock_pkg::NUM_CH;
    localparam int AW = rawsock_pkg::MEM_AW;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [N-1:0][7:0] sopr_ff;
    logic [N-1:0][7:0] ipr_ff;
    logic [15:0] rx_wr_ff [N];
    logic [15:0] rx_rd_ff [N];
    logic [15:0] tx_wr_ff [N];
    logic [15:0] tx_rd_ff [N];
    logic [7:0] mask_ff;
    logic [47:0] hwaddr_ff;
    logic [N-1:0] ip_act_ff;
    logic mac_ff;
    logic [15:0] rd_data_ff;

    wire [3:0] grp = reg_addr[5:2];
    wire [1:0] wch = reg_addr[1:0];
    wire cmd_wr = reg_wr && reg_addr == rawsock_pkg::CMD_ADDR;
    wire [1:0] cmd_ch = reg_wdata[1:0];
    wire cmd_ok = !mac_ff || cmd_ch == 2'h0;
    wire init_cmd = cmd_wr && reg_wdata[rawsock_pkg::CMD_INIT_BIT] && cmd_ok;
    wire send_cmd = cmd_wr && reg_wdata[rawsock_pkg::CMD_SEND_BIT] && cmd_ok;
    wire [3:0] init_code = sopr_ff[cmd_ch][3:0];
    wire stat_rd = reg_rd && reg_addr == rawsock_pkg::INT_STAT_ADDR;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                sopr_ff[i] <= rawsock_pkg::OPT_RST;
                ipr_ff[i] <= rawsock_pkg::OPT_RST;
                rx_rd_ff[i] <= rawsock_pkg::PTR_RST;
                tx_wr_ff[i] <= rawsock_pkg::PTR_RST;
            end
            mask_ff <= 8'h00;
            hwaddr_ff <= rawsock_pkg::HWADDR_RST;
        end else if (reg_wr) begin
            case (grp)
                rawsock_pkg::GRP_SOPR: sopr_ff[wch] <= reg_wdata[7:0];
                rawsock_pkg::GRP_IPR: ipr_ff[wch] <= reg_wdata[7:0];
                rawsock_pkg::GRP_RXRD: rx_rd_ff[wch] <= reg_wdata;
                rawsock_pkg::GRP_TXWR: tx_wr_ff[wch] <= reg_wdata;
                default: begin
                    if (reg_addr == rawsock_pkg::INT_MASK_ADDR) mask_ff <= reg_wdata[7:0];
                    if (reg_addr == rawsock_pkg::HWADDR_HI_ADDR) hwaddr_ff[47:32] <= reg_wdata;
                    if (reg_addr == rawsock_pkg::HWADDR_MID_ADDR) hwaddr_ff[31:16] <= reg_wdata;
                    if (reg_addr == rawsock_pkg::HWADDR_LO_ADDR) hwaddr_ff[15:0] <= reg_wdata;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode selection on the initialisation command
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ip_act_ff <= '0;
            mac_ff <= 1'b0;
        end else if (init_cmd) begin
            if (cmd_ch == 2'h0 && init_code == rawsock_pkg::MAC_RAW_PROTOCOL_CODE) begin
                mac_ff <= 1'b1;
                ip_act_ff <= '0;
            end else begin
                ip_act_ff[cmd_ch] <= init_code == rawsock_pkg::IP_RAW_PROTOCOL_CODE;
                if (cmd_ch == 2'h0) mac_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Receive record writer
    // ------------------------------------------------------------
    rawsock_pkg::rx_state_e rx_st_ff;
    logic [1:0] rx_ch_ff;
    logic [15:0] rx_cnt_ff;
    logic [15:0] rx_hdr_ff;
    logic [2:0] rx_hidx_ff;
    logic [31:0] rx_sip_ff;
    logic [7:0] rx_stt_ff;
    logic rx_ovf_ff;
    logic rxm_we_ff;
    logic [AW-1:0] rxm_addr_ff;
    logic [7:0] rxm_wdata_ff;
    logic [N-1:0] rx_done;
    logic flt_accept;
    logic [1:0] flt_ch;
    logic [7:0] hdr_byte;

    rx_accept_filter u_filter (
        .mac_mode(mac_ff),
        .ip_act(ip_act_ff),
        .ipr(ipr_ff),
        .opt_bcast(sopr_ff[0][rawsock_pkg::OPT_BCAST_BIT]),
        .opt_promisc(sopr_ff[0][rawsock_pkg::OPT_PROMISC_BIT]),
        .is_ip(rx_is_ip),
        .ip_proto(rx_ip_proto),
        .dst_match(rx_dst_match),
        .bcast(rx_bcast),
        .accept(flt_accept),
        .chan(flt_ch)
    );

    wire [15:0] rx_size = mac_ff ? rawsock_pkg::FULL_MEM_SIZE : rawsock_pkg::CHAN_MEM_SIZE;
    wire [15:0] rx_mask = mac_ff ? rawsock_pkg::FULL_MEM_MASK : rawsock_pkg::CHAN_MEM_MASK;
    wire [15:0] rx_base = mac_ff ? 16'h0000 : {3'h0, rx_ch_ff, 11'h000};
    wire [15:0] rx_free = rx_size - (rx_wr_ff[rx_ch_ff] - rx_rd_ff[rx_ch_ff]);
    wire [15:0] rx_len = rx_hdr_ff + rx_cnt_ff;
    wire [15:0] rx_doff = rx_wr_ff[rx_ch_ff] + rx_len;
    wire [15:0] rx_hoff = rx_wr_ff[rx_ch_ff] + {13'h0000, rx_hidx_ff};
    wire rx_fits = rx_len < rx_free;
    wire err_ok = !mac_ff || !rx_frame_err || sopr_ff[0][rawsock_pkg::OPT_ERR_BIT];
    wire rx_keep = !rx_ovf_ff && rx_len <= rx_free && err_ok;
    wire rx_hlast = {13'h0000, rx_hidx_ff} == rx_hdr_ff - 16'h0001;

    always_comb begin
        case (rx_hidx_ff)
            3'h0: hdr_byte = rx_len[15:8];
            3'h1: hdr_byte = rx_len[7:0];
            3'h2: hdr_byte = mac_ff ? rx_stt_ff : rx_sip_ff[31:24];
            3'h3: hdr_byte = rx_sip_ff[23:16];
            3'h4: hdr_byte = rx_sip_ff[15:8];
            default: hdr_byte = rx_sip_ff[7:0];
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_st_ff <= rawsock_pkg::RX_IDLE;
            rx_ch_ff <= 2'h0;
            rx_cnt_ff <= 16'h0000;
            rx_hdr_ff <= rawsock_pkg::IP_HDR_LEN;
            rx_hidx_ff <= 3'h0;
            rx_sip_ff <= 32'h00000000;
            rx_stt_ff <= 8'h00;
            rx_ovf_ff <= 1'b0;
            rxm_we_ff <= 1'b0;
            rxm_addr_ff <= '0;
            rxm_wdata_ff <= 8'h00;
            rx_done <= '0;
            for (int i = 0; i < N; i++) rx_wr_ff[i] <= rawsock_pkg::PTR_RST;
        end else begin
            rxm_we_ff <= 1'b0;
            rx_done <= '0;
            if (init_cmd) rx_wr_ff[cmd_ch] <= rx_rd_ff[cmd_ch];
            case (rx_st_ff)
                rawsock_pkg::RX_IDLE: begin
                    if (rx_frame_start && flt_accept) begin
                        rx_st_ff <= rawsock_pkg::RX_DATA;
                        rx_ch_ff <= flt_ch;
                        rx_cnt_ff <= 16'h0000;
                        rx_ovf_ff <= 1'b0;
                        rx_sip_ff <= rx_src_ip;
                        rx_hdr_ff <= mac_ff ? rawsock_pkg::MAC_HDR_LEN : rawsock_pkg::IP_HDR_LEN;
                        rx_stt_ff <= 8'h00;
                        rx_stt_ff[rawsock_pkg::STT_MATCH_BIT] <= rx_dst_match;
                        rx_stt_ff[rawsock_pkg::STT_BCAST_BIT] <= rx_bcast;
                    end
                end
                rawsock_pkg::RX_DATA: begin
                    if (rx_frame_end) begin
                        rx_stt_ff[rawsock_pkg::STT_ERR_BIT] <= rx_frame_err;
                        rx_hidx_ff <= 3'h0;
                        // Drop leaves memory content unused and pointer still
                        rx_st_ff <= rx_keep ? rawsock_pkg::RX_HDR : rawsock_pkg::RX_IDLE;
                    end else if (rx_byte_valid) begin
                        if (rx_fits && !rx_ovf_ff) begin
                            rxm_we_ff <= 1'b1;
                            rxm_addr_ff <= AW'(rx_base + (rx_doff & rx_mask));
                            rxm_wdata_ff <= rx_byte;
                            rx_cnt_ff <= rx_cnt_ff + 16'h0001;
                        end else begin
                            rx_ovf_ff <= 1'b1;
                        end
                    end
                end
                rawsock_pkg::RX_HDR: begin
                    rxm_we_ff <= 1'b1;
                    rxm_addr_ff <= AW'(rx_base + (rx_hoff & rx_mask));
                    rxm_wdata_ff <= hdr_byte;
                    rx_hidx_ff <= rx_hidx_ff + 3'h1;
                    if (rx_hlast) begin
                        rx_wr_ff[rx_ch_ff] <= rx_wr_ff[rx_ch_ff] + rx_len;
                        rx_done[rx_ch_ff] <= 1'b1;
                        rx_st_ff <= rawsock_pkg::RX_IDLE;
                    end
                end
                default: rx_st_ff <= rawsock_pkg::RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmit reader
    // ------------------------------------------------------------
    rawsock_pkg::tx_state_e tx_st_ff;
    logic [1:0] tx_ch_ff;
    logic [AW-1:0] txm_addr_ff;
    logic tx_valid_ff;
    logic [7:0] tx_data_ff;
    logic tx_last_ff;
    logic tx_mac_ff;
    logic [7:0] tx_proto_ff;
    logic [N-1:0] tx_done;

    wire [1:0] tch = (tx_st_ff == rawsock_pkg::TX_IDLE) ? cmd_ch : tx_ch_ff;
    wire [15:0] tx_mask = mac_ff ? rawsock_pkg::FULL_MEM_MASK : rawsock_pkg::CHAN_MEM_MASK;
    wire [15:0] tx_base = mac_ff ? 16'h0000 : {3'h0, tch, 11'h000};
    wire [15:0] tx_nrd = tx_rd_ff[tch] + 16'h0001;
    wire tx_mode_ok = mac_ff || ip_act_ff[cmd_ch];
    wire tx_go = send_cmd && tx_mode_ok && tx_rd_ff[cmd_ch] != tx_wr_ff[cmd_ch];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_st_ff <= rawsock_pkg::TX_IDLE;
            tx_ch_ff <= 2'h0;
            txm_addr_ff <= '0;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            tx_last_ff <= 1'b0;
            tx_mac_ff <= 1'b0;
            tx_proto_ff <= 8'h00;
            tx_done <= '0;
            for (int i = 0; i < N; i++) tx_rd_ff[i] <= rawsock_pkg::PTR_RST;
        end else begin
            tx_done <= '0;
            if (init_cmd && tx_st_ff == rawsock_pkg::TX_IDLE) tx_rd_ff[cmd_ch] <= tx_wr_ff[cmd_ch];
            case (tx_st_ff)
                rawsock_pkg::TX_IDLE: begin
                    if (tx_go) begin
                        tx_ch_ff <= cmd_ch;
                        tx_mac_ff <= mac_ff;
                        tx_proto_ff <= ipr_ff[cmd_ch];
                        txm_addr_ff <= AW'(tx_base + (tx_rd_ff[cmd_ch] & tx_mask));
                        tx_st_ff <= rawsock_pkg::TX_ADDR;
                    end
                end
                rawsock_pkg::TX_ADDR: tx_st_ff <= rawsock_pkg::TX_READ;
                rawsock_pkg::TX_READ: begin
                    tx_valid_ff <= 1'b1;
                    tx_data_ff <= txm_rdata;
                    tx_last_ff <= tx_nrd == tx_wr_ff[tx_ch_ff];
                    tx_st_ff <= rawsock_pkg::TX_SEND;
                end
                rawsock_pkg::TX_SEND: begin
                    if (tx_ready) begin
                        tx_valid_ff <= 1'b0;
                        tx_last_ff <= 1'b0;
                        tx_rd_ff[tx_ch_ff] <= tx_nrd;
                        txm_addr_ff <= AW'(tx_base + (tx_nrd & tx_mask));
                        if (tx_last_ff) begin
                            tx_done[tx_ch_ff] <= 1'b1;
                            tx_st_ff <= rawsock_pkg::TX_IDLE;
                        end else begin
                            tx_st_ff <= rawsock_pkg::TX_ADDR;
                        end
                    end
                end
                default: tx_st_ff <= rawsock_pkg::TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupts and read-back
    // ------------------------------------------------------------
    logic [7:0] int_stat;
    logic irq_lvl;

    sticky_irq #(.W(8)) u_irq (
        .sys_clk(sys_clk),
        .rst(rst),
        .set({tx_done, rx_done}),
        .clr(stat_rd),
        .mask(mask_ff),
        .status(int_stat),
        .irq(irq_lvl)
    );

    logic [15:0] rd_mux;
    wire [15:0] mode_stat = {9'h000, tx_st_ff != rawsock_pkg::TX_IDLE,
                             rx_st_ff != rawsock_pkg::RX_IDLE, mac_ff, ip_act_ff};

    always_comb begin
        case (grp)
            rawsock_pkg::GRP_SOPR: rd_mux = {8'h00, sopr_ff[wch]};
            rawsock_pkg::GRP_IPR: rd_mux = {8'h00, ipr_ff[wch]};
            rawsock_pkg::GRP_RXWR: rd_mux = rx_wr_ff[wch];
            rawsock_pkg::GRP_RXRD: rd_mux = rx_rd_ff[wch];
            rawsock_pkg::GRP_TXWR: rd_mux = tx_wr_ff[wch];
            rawsock_pkg::GRP_TXRD: rd_mux = tx_rd_ff[wch];
            default: begin
                case (reg_addr)
                    rawsock_pkg::INT_STAT_ADDR: rd_mux = {8'h00, int_stat};
                    rawsock_pkg::INT_MASK_ADDR: rd_mux = {8'h00, mask_ff};
                    rawsock_pkg::MODE_STAT_ADDR: rd_mux = mode_stat;
                    rawsock_pkg::HWADDR_HI_ADDR: rd_mux = hwaddr_ff[47:32];
                    rawsock_pkg::HWADDR_MID_ADDR: rd_mux = hwaddr_ff[31:16];
                    rawsock_pkg::HWADDR_LO_ADDR: rd_mux = hwaddr_ff[15:0];
                    default: rd_mux = 16'h0000;
                endcase
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) rd_data_ff <= 16'h0000;
        else if (reg_rd) rd_data_ff <= rd_mux;
    end

    assign reg_rdata = rd_data_ff;
    assign irq = irq_lvl;
    assign rxm_we = rxm_we_ff;
    assign rxm_addr = rxm_addr_ff;
    assign rxm_wdata = rxm_wdata_ff;
    assign txm_addr = txm_addr_ff;
    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;
    assign tx_last = tx_last_ff;
    assign tx_mac_raw = tx_mac_ff;
    assign tx_ip_proto = tx_proto_ff;
endmodule

// file: verif/rawsock_chk.sv
// Port checker for the raw socket channel.
// Assumes it is bound onto raw_mode_socket_channel.
`timescale 1ns/1ps
module rawsock_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic irq,
    input wire logic rx_byte_valid,
    input wire logic rx_frame_end,
    input wire logic rxm_we,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_mac_raw,
    input wire logic [7:0] tx_ip_proto,
    input wire logic tx_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    tx_hold_a:
        assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_last}))
        else $error("tx byte moved before taken");
    tx_gap_a:
        assert property (tx_valid && tx_ready |=> !tx_valid ##1 !tx_valid)
        else $error("tx byte too soon");
    tx_attr_a:
        assert property (tx_valid && $past(tx_valid) |-> $stable({tx_mac_raw, tx_ip_proto}))
        else $error("tx attributes moved");
    hdr_burst_a:
        assert property (rx_frame_end ##2 rxm_we |=> rxm_we [*2])
        else $error("header writes broken");
    we_cause_a:
        assert property (rxm_we |-> $past(rx_byte_valid) || $past(rxm_we) || $past(rx_frame_end, 2))
        else $error("stray memory write");
    irq_cause_a:
        assert property ($rose(irq) |-> $past(rxm_we) || $past(tx_last) || $past(tx_last, 2)
            || $past(reg_wr) || $past(reg_wr, 2)) else $error("irq without cause");
    rd_hold_a:
        assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
    unmapped_rd_a:
        assert property (reg_rd && reg_addr == 6'h1F |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    irq_c: cover property ($rose(irq));
    hdr_c: cover property (rx_frame_end ##2 rxm_we);
    txl_c: cover property (tx_valid && tx_ready && tx_last);
endmodule
bind raw_mode_socket_channel rawsock_chk u_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end), .rxm_we(rxm_we),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_mac_raw(tx_mac_raw),
    .tx_ip_proto(tx_ip_proto), .tx_ready(tx_ready));

// file: verif/host_buf_model.sv
// Host side buffers: receive memory image, transmit memory with one-cycle reads.
// Assumes the device memory ports run on sys_clk.
`timescale 1ns/1ps
module host_buf_model (
    input wire logic sys_clk,
    input wire logic rxm_we,
    input wire logic [12:0] rxm_addr,
    input wire logic [7:0] rxm_wdata,
    input wire logic [12:0] txm_addr,
    output logic [7:0] txm_rdata
);
    logic [7:0] rx_mem [0:8191];
    // Frame bytes the host copied in, as a pattern of the address
    always_ff @(posedge sys_clk) begin
        txm_rdata <= txm_addr[7:0] ^ 8'h5A;
        if (rxm_we) begin
            rx_mem[rxm_addr] <= rxm_wdata;
        end
    end
endmodule

// file: verif/tb_raw_mode_socket_channel.sv
// Self-checking bench for the raw socket channel.
// Assumes the host buffer model beside the device and the bound checker.
`timescale 1ns/1ps
module tb_raw_mode_socket_channel;
    logic sys_clk, rst, reg_wr, reg_rd, irq, rx_frame_start, rx_is_ip, rx_dst_match, rx_bcast;
    logic rx_byte_valid, rx_frame_end, rx_frame_err, rxm_we, tx_valid, tx_last, tx_mac_raw;
    logic tx_ready;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, eptr;
    logic [7:0] rx_ip_proto, rx_byte, rxm_wdata, txm_rdata, tx_data, tx_ip_proto;
    logic [12:0] rxm_addr, txm_addr;
    logic [31:0] rx_src_ip, seed;
    logic [7:0] bq [0:7];
    int err_count, tests_run, cyc, i;
    raw_mode_socket_channel u_dut (.*);
    host_buf_model u_host (.*);
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask
    // IP records land in the channel 1 window, MAC records in the full memory
    task automatic rx_case(input logic [5:0] pa, input logic ip, input logic [7:0] pr,
        input logic m, input logic b, input logic e, input logic acc, input logic [7:0] frame_status_byte);
        logic [15:0] len;
        logic [31:0] sender_ip_field;
        int n, a, hdr;
        seed = lfsr(seed);
        sender_ip_field = seed;
        n = 2 + int'(seed[9:8]);
        @(posedge sys_clk);
        {rx_frame_start, rx_is_ip, rx_ip_proto, rx_src_ip} <= {1'h1, ip, pr, sender_ip_field};
        {rx_dst_match, rx_bcast} <= {m, b};
        for (int k = 0; k < n; k++) begin
            seed = lfsr(seed);
            bq[k] = seed[7:0];
            @(posedge sys_clk);
            {rx_frame_start, rx_byte_valid, rx_byte} <= {2'h1, bq[k]};
        end
        @(posedge sys_clk);
        {rx_byte_valid, rx_frame_end, rx_frame_err} <= {2'h1, e};
        @(posedge sys_clk);
        {rx_frame_end, rx_frame_err} <= 2'h0;
        repeat (10) @(posedge sys_clk);
        hdr = ip ? 6 : 3;
        len = 16'(hdr + n);
        a = ip ? 32'h0800 + eptr[10:0] : int'(eptr[12:0]);
        if (acc) begin
            chk(u_host.rx_mem[a], len[15:8]);
            chk(u_host.rx_mem[a + 1], len[7:0]);
            for (int k = 0; k < hdr - 2; k++) begin
                chk(u_host.rx_mem[a + 2 + k], ip ? sender_ip_field[31 - 8 * k -: 8] : frame_status_byte);
            end
            for (int k = 0; k < n; k++) begin
                chk(u_host.rx_mem[a + hdr + k], bq[k]);
            end
            eptr = eptr + len;
        end
        rdchk(pa, eptr);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, rx_frame_start, rx_is_ip, rx_ip_proto} = '0;
        {rx_src_ip, rx_dst_match, rx_bcast, rx_byte_valid, rx_byte, rx_frame_end} = '0;
        {rx_frame_err, tx_ready, eptr, err_count, tests_run, cyc} = '0;
        rst = 1'h1;
        seed = 32'he11f268e;
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        rdchk(6'h1B, 16'h0000);
        rdchk(6'h1F, 16'h0000);
        wr(6'h05, 16'h0001);
        wr(6'h01, 16'h0003);
        wr(6'h18, 16'h0101);
        wr(6'h1A, 16'h00FF);
        rx_case(6'h09, 1'h1, 8'h01, 1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
        chk(irq, 1'h1);
        rdchk(6'h19, 16'h0002);
        chk(irq, 1'h0);
        rx_case(6'h09, 1'h1, 8'h06, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
        rx_case(6'h09, 1'h0, 8'h01, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
        wr(6'h1A, 16'h0000);
        rx_case(6'h09, 1'h1, 8'h01, 1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
        chk(irq, 1'h0);
        rdchk(6'h19, 16'h0002);
        wr(6'h0C, 16'h1800);
        wr(6'h10, 16'h1000);
        wr(6'h00, 16'h0044);
        wr(6'h18, 16'h0100);
        eptr = 16'h1800;
        wr(6'h18, 16'h0101);
        rdchk(6'h1B, 16'h0010);
        wr(6'h1A, 16'h0001);
        rx_case(6'h08, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0, 1'h1, 8'h80);
        chk(irq, 1'h1);
        rx_case(6'h08, 1'h0, 8'h00, 1'h0, 1'h1, 1'h0, 1'h1, 8'h20);
        rx_case(6'h08, 1'h0, 8'h00, 1'h1, 1'h0, 1'h1, 1'h0, 8'h00);
        rx_case(6'h08, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
        wr(6'h00, 16'h00A4);
        rx_case(6'h08, 1'h0, 8'h00, 1'h0, 1'h0, 1'h1, 1'h1, 8'h10);
        rdchk(6'h19, 16'h0001);
        wr(6'h10, 16'h1006);
        wr(6'h18, 16'h0200);
        i = 0;
        repeat (150) begin
            @(negedge sys_clk);
            if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
                chk(tx_data, 8'h5A ^ 8'(i));
                chk({tx_mac_raw, tx_last, tx_ip_proto}, {1'h1, i == 5, 8'h00});
                i++;
            end
            @(posedge sys_clk);
            seed = lfsr(seed);
            tx_ready <= seed[0];
        end
        chk(16'(i), 16'h0006);
        rdchk(6'h14, 16'h1006);
        rdchk(6'h19, 16'h0010);
        tally_and_finish();
    end
endmodule
